//--- include/irq_map_consts.svh
// Constants for the interrupt vector and wakeup map.
// Assumes inclusion by bare name from the package and the design files.
`ifndef IRQ_MAP_CONSTS_SVH
`define IRQ_MAP_CONSTS_SVH

`define VEC_RESET_ADDR    24'h00_8000
`define VEC_TRAP_ADDR     24'h00_8004
`define VEC_NUMBERED_BASE 24'h00_8008
`define VEC_STRIDE        24'h00_0004
`define IRQ_COUNT         19
`define IRQ_NUM_WIDTH     5
// Wakeup capability per request, bit n is request n
`define WAKE_HALT_MASK    19'h4_fff0
`define WAKE_WAIT_MASK    19'h6_fffe
`define FLASH_SRC_COUNT   2
`define DMA_SRC_COUNT     4
`define RTC_SRC_COUNT     5
`define CLK_SRC_COUNT     2
`define ADC_SRC_COUNT     3
`define PIN_LINE_COUNT    8

`endif

//--- include/irq_map_pkg.sv
// Types for the interrupt vector and wakeup map.
// Assumes irq_map_consts.svh sits on the include path.
`include "irq_map_consts.svh"
package irq_map_pkg;
  typedef enum logic [2:0] {
    mode_run,
    mode_halt,
    mode_active_halt,
    mode_wait_for_interrupt_flavour,
    mode_wait_for_event_flavour
  } power_mode_type;

  typedef enum logic [1:0] {
    fetch_idle,
    fetch_reset,
    fetch_trap,
    fetch_numbered
  } fetch_kind_type;
endpackage : irq_map_pkg

//--- hw/irq_vector_rom.sv
// Vector address table, one entry per fetch kind and request number.
// Assumes a synchronous read on the core clock; data out is registered.
`timescale 1ns/1ns
`include "irq_map_consts.svh"
module irq_vector_rom
  import irq_map_pkg::*;
(
  input  wire logic                        clk,      // System clock
  input  wire logic                        rst_b,    // Async reset, low
  input  wire fetch_kind_type              kind,     // Which entry
  input  wire logic [`IRQ_NUM_WIDTH-1:0]   number,   // Request number
  output logic      [23:0]                 address   // Registered vector
);
  typedef struct packed {
    logic [23:0] address;
  } rom_state_type;

  rom_state_type state;
  rom_state_type next_state;

  // Entries sit at a fixed 4-byte stride
  always_comb begin
    next_state = state;
    case (kind)
      fetch_reset: next_state.address = `VEC_RESET_ADDR;
      fetch_trap:  next_state.address = `VEC_TRAP_ADDR;
      fetch_numbered: next_state.address = `VEC_NUMBERED_BASE
        + {17'h0_0000, number, 2'b00};
      default:     next_state.address = state.address;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '{address: `VEC_RESET_ADDR};
    end else begin
      state <= next_state;
    end
  end

  assign address = state.address;
endmodule : irq_vector_rom

//--- hw/irq_vector_wakeup_map.sv
// Interrupt source gather, vector selection and low-power wakeup decision.
// Assumes requests are levels on clk; the core acknowledges each fetch.
`timescale 1ns/1ns
`include "irq_map_consts.svh"
// Notes on behaviour
// - Vectors at 4-byte stride: reset, trap, then numbered base plus 4n.
// - Top-level request is number 0 and never wakes the core.
// - Flash events form request 1, waking only from Wait flavours.
// - DMA channels 0/1 form request 2, 2/3 request 3; Wait only.
// - RTC alarm, wakeup and three tampers form request 4; wakes all.
// - Port B pin request is number 6 and wakes from every mode.
// - Port D pin request is number 7 and wakes from every mode.
// - Clock switch and security form 17, Wait only; 16 reserved.
// - Converter events form request 18, waking from every mode.
// - In event-wait, enabled interrupts serve; wakeup events resume.
// - Top-level request is OR of timer 2 and timer 4 overflows.
module irq_vector_wakeup_map
  import irq_map_pkg::*;
(
  input  wire logic                       clk,                  // Clock
  input  wire logic                       rst_b,                // Reset
  input  wire logic                       timer2_overflow,      // Timer 2
  input  wire logic                       timer4_overflow,      // Timer 4
  input  wire logic [`FLASH_SRC_COUNT-1:0] flash_events,        // Flash
  input  wire logic [`DMA_SRC_COUNT-1:0]  dma_events,           // DMA 0..3
  input  wire logic [`RTC_SRC_COUNT-1:0]  rtc_events,           // RTC
  input  wire logic                       voltage_detector_request, // Vdet
  input  wire logic                       port_b_pin_request,   // Port B
  input  wire logic                       port_d_pin_request,   // Port D
  input  wire logic [`PIN_LINE_COUNT-1:0] pin_line_request,     // Lines
  input  wire logic [`CLK_SRC_COUNT-1:0]  clock_events,         // Clock
  input  wire logic [`ADC_SRC_COUNT-1:0]  adc_events,           // ADC
  input  wire logic [`IRQ_COUNT-1:0]      irq_enable,           // Enables
  input  wire logic [`IRQ_COUNT-1:0]      wakeup_event_select,  // Event
  input  wire power_mode_type             power_mode,           // Mode
  input  wire logic                       reset_request,        // Reset
  input  wire logic                       trap_request,         // Trap
  input  wire logic                       fetch_ack,            // Taken
  output logic                            vector_valid,         // Valid
  output logic      [23:0]                vector_address,       // Address
  output logic      [`IRQ_NUM_WIDTH-1:0]  vector_number,        // Number
  output logic                            wake_core,            // Wake
  output logic                            serve_and_return      // WAIT_FOR_EVENT_FLAVOUR svc
);
  // Number of numbered requests served here
  localparam int N = `IRQ_COUNT;

  // Fetch in flight and registered wake decisions
  typedef struct packed {
    logic                      pending;
    fetch_kind_type            kind;
    logic [`IRQ_NUM_WIDTH-1:0] number;
    logic                      rom_ready;
    logic                      wake;
    logic                      serve;
  } map_state_type;

  map_state_type state;
  map_state_type next_state;

  logic [N-1:0]              request;
  logic [N-1:0]              active;
  logic [N-1:0]              wake_capable;
  logic                      found;
  logic [`IRQ_NUM_WIDTH-1:0] lowest;
  fetch_kind_type            rom_kind;
  logic [23:0]               rom_address;
  logic [N-1:0]              event_wake;
  logic [N-1:0]              interrupt_wake;
  logic [N-1:0]              serve_here;
  logic                      any_event_wake;
  logic                      any_interrupt_wake;
  logic                      any_serve;
  logic                      in_low_power;
  logic                      wake_now;
  logic                      serve_now;
  logic                      take_allowed;
  logic                      trap_allowed;
  logic                      numbered_allowed;

  // Wake masks per request, bit n is request n
  localparam logic [N-1:0] HALT_WAKE = `WAKE_HALT_MASK;
  localparam logic [N-1:0] WAIT_WAKE = `WAKE_WAIT_MASK;

  // Gather sources into numbered requests
  always_comb begin
    request     = '0;
    request[0]  = timer2_overflow | timer4_overflow;
    request[1]  = |flash_events;
    request[2]  = |dma_events[1:0];
    request[3]  = |dma_events[3:2];
    request[4]  = |rtc_events;
    request[5]  = voltage_detector_request;
    request[6]  = port_b_pin_request;
    request[7]  = port_d_pin_request;
    request[15:8] = pin_line_request;
    request[16] = 1'b0;
    request[17] = |clock_events;
    request[18] = |adc_events;
  end

  // Only enabled requests compete for a vector
  assign active = request & irq_enable;

  // Wake ability of each request in the current mode
  always_comb begin
    case (power_mode)
      mode_halt, mode_active_halt:
        wake_capable = HALT_WAKE;
      mode_wait_for_interrupt_flavour, mode_wait_for_event_flavour:
        wake_capable = WAIT_WAKE;
      default:
        wake_capable = '0;
    endcase
  end

  // Per request: event wake, interrupt wake and event-wait service
  for (genvar n = 0; n < N; n++) begin : g_request
    assign event_wake[n]     = request[n] & wakeup_event_select[n]
                               & wake_capable[n];
    assign interrupt_wake[n] = active[n] & wake_capable[n];
    assign serve_here[n]     = active[n] & ~wakeup_event_select[n]
                               & wake_capable[n];
  end

  // Fold the per-request terms
  assign in_low_power       = (power_mode != mode_run);
  assign any_event_wake     = |event_wake;
  assign any_interrupt_wake = |interrupt_wake;
  assign any_serve          = |serve_here;

  // Lowest numbered active request wins
  always_comb begin
    found  = 1'b0;
    lowest = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (active[i]) begin
        found  = 1'b1;
        lowest = i[`IRQ_NUM_WIDTH-1:0];
      end
    end
  end

  // Wake and event-wait service decision for the current mode
  always_comb begin
    wake_now  = 1'b0;
    serve_now = 1'b0;
    if (power_mode == mode_wait_for_event_flavour) begin
      // Wakeup events resume; plain interrupts are served then sleep
      wake_now  = any_event_wake | reset_request;
      serve_now = any_serve;
    end else if (in_low_power) begin
      wake_now  = any_interrupt_wake | reset_request;
    end
  end

  // Fetch causes: trap only in run; numbered in run, event-wait or on wake
  assign take_allowed     = !state.pending && !state.rom_ready;
  assign trap_allowed     = trap_request && !in_low_power;
  assign numbered_allowed = found && (!in_low_power || wake_now
                            || power_mode == mode_wait_for_event_flavour);

  // Pick what to fetch: reset first, then trap, then lowest request
  always_comb begin
    rom_kind = fetch_idle;
    if (take_allowed) begin
      if (reset_request) begin
        rom_kind = fetch_reset;
      end else if (trap_allowed) begin
        rom_kind = fetch_trap;
      end else if (numbered_allowed) begin
        rom_kind = fetch_numbered;
      end
    end
  end

  // Latch the fetch, then offer it until the core takes it
  always_comb begin
    next_state           = state;
    next_state.rom_ready = 1'b0;
    next_state.wake      = wake_now;
    next_state.serve     = serve_now;
    if (state.pending && fetch_ack) begin
      next_state.pending = 1'b0;
    end else if (rom_kind != fetch_idle) begin
      next_state.kind      = rom_kind;
      next_state.number    = lowest;
      next_state.rom_ready = 1'b1;
    end else if (state.rom_ready) begin
      next_state.pending = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '{pending:   1'b0,
                 kind:      fetch_idle,
                 number:    '0,
                 rom_ready: 1'b0,
                 wake:      1'b0,
                 serve:     1'b0};
    end else begin
      state <= next_state;
    end
  end

  // Vector table, loaded on the take edge
  irq_vector_rom vector_table (
    .clk     (clk),
    .rst_b   (rst_b),
    .kind    (rom_kind),
    .number  (lowest),
    .address (rom_address)
  );

  // Outputs straight from registers
  assign vector_valid     = state.pending;
  assign vector_address   = rom_address;
  assign vector_number    = state.number;
  assign wake_core        = state.wake;
  assign serve_and_return = state.serve;
endmodule : irq_vector_wakeup_map

//--- verif/irq_core_model.sv
// Behavioural core that takes each offered vector after a set wait.
// Assumes vector_valid stands until the edge that samples fetch_ack.
`timescale 1ns/1ns
module irq_core_model (
  input  wire logic        clk,            // Clock
  input  wire logic        rst_b,          // Async reset, low
  input  wire logic [1:0]  ack_wait,       // Cycles before taking
  input  wire logic        vector_valid,   // Vector offered
  input  wire logic [23:0] vector_address, // Offered address
  input  wire logic [4:0]  vector_number,  // Offered number
  output logic             fetch_ack,      // Take pulse
  output logic [23:0]      taken_address,  // Last address taken
  output logic [4:0]       taken_number,   // Last number taken
  output int               taken_count     // Fetches so far
);
  logic [1:0] cnt;

  // Wait, pulse ack once, record what the ack edge took
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 2'h0;
      fetch_ack <= 1'b0;
      taken_address <= 24'h00_0000;
      taken_number <= 5'h00;
      taken_count <= 0;
    end else begin
      fetch_ack <= 1'b0;
      if (fetch_ack && vector_valid) begin
        taken_address <= vector_address;
        taken_number <= vector_number;
        taken_count <= taken_count + 1;
      end else if (vector_valid && cnt == ack_wait) begin
        fetch_ack <= 1'b1;
        cnt <= 2'h0;
      end else if (vector_valid) begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule : irq_core_model

//--- verif/irq_vector_wakeup_map_monitor.sv
// Port checker for the vector and wakeup map.
// Assumes it is bound onto the top module and sees its ports only.
`timescale 1ns/1ns
module irq_map_monitor
  import irq_map_pkg::*;
(
  input wire logic           clk,                // Clock
  input wire logic           rst_b,              // Async reset, low
  input wire logic           fetch_ack,          // Core takes vector
  input wire power_mode_type power_mode,         // Mode
  input wire logic           port_b_pin_request, // Port B
  input wire logic           port_d_pin_request, // Port D
  input wire logic [4:0]     rtc_events,         // RTC
  input wire logic [2:0]     adc_events,         // ADC
  input wire logic [18:0]    irq_enable,         // Enables
  input wire logic           vector_valid,       // Valid
  input wire logic [23:0]    vector_address,     // Address
  input wire logic [4:0]     vector_number,      // Number
  input wire logic           wake_core           // Wake
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_vector_holds: assert property (vector_valid && !fetch_ack |=>
    vector_valid && $stable(vector_address) && $stable(vector_number))
    else $error("vector changed before ack");
  a_ack_drops: assert property (vector_valid && fetch_ack |=>
    !vector_valid) else $error("vector stayed after ack");
  a_vector_stride: assert property (vector_valid &&
    vector_address >= 24'h00_8008 |-> vector_address ==
    24'h00_8008 + 24'(vector_number) * 24'h00_0004)
    else $error("vector address off stride");
  a_number_reserved: assert property (vector_valid |->
    vector_number != 5'h10 && vector_number < 5'h13)
    else $error("reserved or unknown request served");
  a_wake_port_b: assert property (power_mode == mode_halt &&
    port_b_pin_request && irq_enable[6] |=> wake_core)
    else $error("port B did not wake halt");
  a_wake_port_d: assert property (power_mode == mode_active_halt &&
    port_d_pin_request && irq_enable[7] |=> wake_core)
    else $error("port D did not wake active halt");
  a_wake_rtc: assert property (power_mode == mode_halt &&
    |rtc_events && irq_enable[4] |=> wake_core)
    else $error("rtc events did not wake halt");
  a_wake_converter: assert property (power_mode == mode_active_halt &&
    |adc_events && irq_enable[18] |=> wake_core)
    else $error("converter did not wake active halt");
endmodule : irq_map_monitor

bind irq_vector_wakeup_map irq_map_monitor i_mon (.clk(clk), .rst_b(rst_b),
  .fetch_ack(fetch_ack), .power_mode(power_mode),
  .port_b_pin_request(port_b_pin_request),
  .port_d_pin_request(port_d_pin_request), .rtc_events(rtc_events),
  .adc_events(adc_events), .irq_enable(irq_enable),
  .vector_valid(vector_valid), .vector_address(vector_address),
  .vector_number(vector_number), .wake_core(wake_core));

//--- verif/irq_vector_wakeup_map_bench.sv
// Self-checking bench for the vector and wakeup map.
// Assumes the core model acks fetches and the checker is bound.
`timescale 1ns/1ns
module irq_vector_wakeup_map_bench;
  import irq_map_pkg::*;
  logic t2, t4, vdet, pb, pd, rreq, treq, ack, vv, wk, sr, clk, rst_b;
  logic [1:0] fl, ck, aw;
  logic [3:0] dm;
  logic [4:0] rt, vn, tn;
  logic [2:0] ad;
  logic [7:0] pl;
  logic [18:0] en, sel;
  logic [23:0] va, ta;
  power_mode_type mode;
  int tc, miscompares, cmp_count, cyc;

  irq_vector_wakeup_map i_dut (.clk(clk), .rst_b(rst_b),
    .timer2_overflow(t2), .timer4_overflow(t4), .flash_events(fl),
    .dma_events(dm), .rtc_events(rt), .voltage_detector_request(vdet),
    .port_b_pin_request(pb), .port_d_pin_request(pd),
    .pin_line_request(pl), .clock_events(ck), .adc_events(ad),
    .irq_enable(en), .wakeup_event_select(sel), .power_mode(mode),
    .reset_request(rreq), .trap_request(treq), .fetch_ack(ack),
    .vector_valid(vv), .vector_address(va), .vector_number(vn),
    .wake_core(wk), .serve_and_return(sr));
  irq_core_model i_core (.clk(clk), .rst_b(rst_b), .ack_wait(aw),
    .vector_valid(vv), .vector_address(va), .vector_number(vn),
    .fetch_ack(ack), .taken_address(ta), .taken_number(tn),
    .taken_count(tc));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      wrap_up;
    end
  end

  task wrap_up;
    $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task cmp(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  // Source index: 0..18 requests, 19 reset, 20 timer 4, 21 trap
  task drive(input int i, input logic v);
    case (i)
      0: t2 = v;
      1: fl[0] = v;
      2: dm[1] = v;
      3: dm[2] = v;
      4: rt[4] = v;
      5: vdet = v;
      6: pb = v;
      7: pd = v;
      17: ck[1] = v;
      18: ad[0] = v;
      19: rreq = v;
      20: t4 = v;
      21: treq = v;
      default: pl[i-8] = v;
    endcase
  endtask : drive

  task t_vectors;
    int s;
    logic [23:0] e;
    mode = mode_run;
    for (int i = 0; i < 22; i++) begin
      if (i == 16) continue;
      e = (i == 19) ? 24'h00_8000 : (i == 21) ? 24'h00_8004 :
        24'h00_8008 + 24'((i == 20) ? 0 : i) * 24'h00_0004;
      s = tc;
      drive(i, 1'b1);
      @(negedge clk);
      drive(i, 1'b0);
      repeat (20) if (tc == s) @(negedge clk);
      cmp(ta, e);
      if (i < 19 || i == 20) cmp(24'(tn), 24'((i == 20) ? 0 : i));
      @(negedge clk);
    end
    $display("vector test done");
  endtask : t_vectors

  task t_wake(input power_mode_type m, input logic [21:0] exp);
    mode = m;
    aw = 2'h3;
    sel = '1;
    for (int i = 0; i < 22; i++) begin
      if (i == 16) continue;
      drive(i, 1'b1);
      repeat (2) @(negedge clk);
      cmp(24'(wk), 24'(exp[i]));
      cmp(24'(sr), 24'h00_0000);
      drive(i, 1'b0);
      repeat (8) @(negedge clk);
    end
    sel = '0;
    $display("wake test done, mode %0d", m);
  endtask : t_wake

  task t_serve;
    mode = mode_wait_for_event_flavour;
    drive(6, 1'b1);
    repeat (2) @(negedge clk);
    cmp(24'(sr), 24'h00_0001);
    cmp(24'(wk), 24'h00_0000);
    drive(6, 1'b0);
    repeat (8) @(negedge clk);
    // Same source as a wakeup event, interrupt disabled: wake, no service
    sel[6] = 1'b1;
    en[6]  = 1'b0;
    drive(6, 1'b1);
    repeat (2) @(negedge clk);
    cmp(24'(sr), 24'h00_0000);
    cmp(24'(wk), 24'h00_0001);
    drive(6, 1'b0);
    sel[6] = 1'b0;
    en[6]  = 1'b1;
    repeat (8) @(negedge clk);
    $display("event wait serve test done");
  endtask : t_serve

  // Reset values, then release; also used for a reset in mid-run
  task t_reset;
    rst_b = 1'b0;
    @(negedge clk);
    cmp(va, 24'h00_8000);
    cmp(24'({vv, wk, sr}), 24'h00_0000);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    cmp(24'({vv, wk, sr}), 24'h00_0000);
    $display("reset test done");
  endtask : t_reset

  initial begin
    {t2, t4, vdet, pb, pd, rreq, treq} = '0;
    {fl, ck, aw, dm, rt, ad, pl, sel} = '0;
    en = '1;
    mode = mode_run;
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    t_reset;
    t_vectors;
    t_wake(mode_halt, 22'h0c_fff0);
    t_wake(mode_active_halt, 22'h0c_fff0);
    t_wake(mode_wait_for_interrupt_flavour, 22'h0e_fffe);
    t_wake(mode_wait_for_event_flavour, 22'h0e_fffe);
    t_serve;
    t_reset;
    wrap_up;
  end
endmodule : irq_vector_wakeup_map_bench
